// ==== hsc_regs.vh ====
// Register offsets, field positions, status codes and reset values
// for the high-speed counter. Included by the top, the checker and the bench.
`ifndef HSC_REGS_VH
`define HSC_REGS_VH

// Register byte offsets
`define HSC_CTRL_OFF 12'h000
`define HSC_MODE_OFF 12'h004
`define HSC_HIGH_OFF 12'h008
`define HSC_LOW_OFF 12'h00C
`define HSC_OVF_OFF 12'h010
`define HSC_UNF_OFF 12'h014
`define HSC_OMASK_OFF 12'h018
`define HSC_HPAT_OFF 12'h01C
`define HSC_LPAT_OFF 12'h020
`define HSC_ACC_OFF 12'h024
`define HSC_STAT_OFF 12'h028
`define HSC_TCNT_OFF 12'h02C
`define HSC_TIDX_OFF 12'h030
`define HSC_TABLE_OFF 12'h400

// Control register fields
`define HSC_CTRL_RUN 0
`define HSC_CTRL_LSW 1
`define HSC_CTRL_SWRST 2
// Status register fields
`define HSC_ST_HIGH 0
`define HSC_ST_LOW 1
`define HSC_ST_OVF 2
`define HSC_ST_UNF 3
`define HSC_ST_CODE_LSB 8

// Status codes
`define HSC_CODE_IDLE 8'h00
`define HSC_CODE_RUN 8'h01
`define HSC_CODE_BADCFG 8'h04

// Reset values and limits
`define HSC_OVF_RST 32'h7FFFFFFF
`define HSC_UNF_RST 32'h80000000
`define HSC_MAX_INST 3'h5
`define HSC_TABLE_MAX 9'h0FF

`endif

// ==== hsc_sync.v ====
// Three-stage pin synchroniser with agreement check.
// Assumes the pins are asynchronous to hclk.
`timescale 1ns/1ps
module hsc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Pins in, filtered levels out
  input wire [W-1:0] pin_in,
  output reg [W-1:0] level_q
);
  // ------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------
  reg [W-1:0] s1_q; // Metastability stage, read only by s2
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // Shift and accept once second and third stages agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end
endmodule

// ==== hsc_top.v ====
// High-speed counter with presets, limits, masked outputs and a
// limit-switch preset table, reached over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers, pins asynchronous.
`timescale 1ns/1ps
`include "hsc_regs.vh"
module hsc_top #(
  parameter NOUT = 4,
  parameter TDEPTH = 255,
  parameter TAW = 8
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Counter pins: A/up/pulse, B/down/direction, reset, hold
  input wire pin_a,
  input wire pin_b,
  input wire pin_reset,
  input wire pin_hold,
  // Embedded outputs
  output reg [NOUT-1:0] out_q
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg run_q;                       // Counter enabled
  reg limit_switch_enable_q;       // Presets from table
  reg [3:0] count_mode_q;          // Mode 0..9
  reg [2:0] counter_instance_select_q; // Instance 0..5
  reg [31:0] high_preset_q;
  reg [31:0] low_preset_q;
  reg [31:0] overflow_limit_q;
  reg [31:0] underflow_limit_q;
  reg [NOUT-1:0] output_enable_mask_q;
  reg [NOUT-1:0] high_preset_output_pattern_q;
  reg [NOUT-1:0] low_preset_output_pattern_q;
  reg [31:0] acc_q;                // Accumulator
  reg high_preset_hit_flag_q;
  reg low_preset_hit_flag_q;
  reg ovf_flag_q;
  reg unf_flag_q;
  reg [TAW:0] tcnt_q;              // Table entries in use
  reg [TAW-1:0] tidx_q;            // Current table entry
  // Limit-switch table: high, low, high pattern, low pattern
  reg [31:0] tab_high_q [0:TDEPTH-1];
  reg [31:0] tab_low_q [0:TDEPTH-1];
  reg [NOUT-1:0] tab_hpat_q [0:TDEPTH-1];
  reg [NOUT-1:0] tab_lpat_q [0:TDEPTH-1];

  // ------------------------------------------------------------
  // Bus slave: address phase capture
  // ------------------------------------------------------------
  reg wr_q;                        // Pending write data phase
  reg [11:0] wa_q;                 // Write address
  wire acc_phase = hsel & hready & htrans[1];
  wire wr_now = acc_phase & hwrite;
  wire rd_now = acc_phase & ~hwrite;
  wire wr_ev = wr_q;               // Write data valid this cycle
  assign hreadyout = 1'b1;         // Zero wait states
  assign hresp = 1'b0;             // Always OKAY

  // Decode table window
  function is_tab;
    input [11:0] a;
    begin
      is_tab = (a[11:10] == 2'b01);
    end
  endfunction

  // Hold write address into data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 12'h000;
    end else begin
      wr_q <= wr_now;
      if (wr_now) begin
        wa_q <= haddr;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisation and edges
  // ------------------------------------------------------------
  wire [3:0] lvl;
  reg [3:0] lvl_q;
  hsc_sync #(.W(4)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({pin_hold, pin_reset, pin_b, pin_a}),
    .level_q(lvl)
  );
  // Previous filtered levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 4'h0;
    end else begin
      lvl_q <= lvl;
    end
  end
  wire a_rise = lvl[0] & ~lvl_q[0];
  wire a_fall = ~lvl[0] & lvl_q[0];
  wire b_rise = lvl[1] & ~lvl_q[1];
  wire b_fall = ~lvl[1] & lvl_q[1];
  wire ext_rst = lvl[2] & ~lvl_q[2];
  wire ext_hold = lvl[3];

  // ------------------------------------------------------------
  // Configuration check and status code
  // ------------------------------------------------------------
  wire odd_mode = count_mode_q[0];
  wire ext_used = odd_mode;        // Odd modes use reset and hold
  wire inst_ok_odd = (counter_instance_select_q == 3'h0) | (counter_instance_select_q == 3'h2) |
                     (counter_instance_select_q == 3'h4);
  wire bad_cfg = (count_mode_q > 4'h9) |
                 (counter_instance_select_q > `HSC_MAX_INST) |
                 (odd_mode & ~inst_ok_odd) |
                 (limit_switch_enable_q & (tcnt_q == {(TAW+1){1'b0}}));
  wire counting = run_q & ~bad_cfg;
  wire [7:0] code = ~run_q ? `HSC_CODE_IDLE : bad_cfg ? `HSC_CODE_BADCFG : `HSC_CODE_RUN;

  // Active presets: single pair or table entry
  wire [31:0] hp = limit_switch_enable_q ? tab_high_q[tidx_q] : high_preset_q;
  wire [31:0] lp = limit_switch_enable_q ? tab_low_q[tidx_q] : low_preset_q;
  wire [NOUT-1:0] hpat = limit_switch_enable_q ? tab_hpat_q[tidx_q] : high_preset_output_pattern_q;
  wire [NOUT-1:0] lpat = limit_switch_enable_q ? tab_lpat_q[tidx_q] : low_preset_output_pattern_q;

  // ------------------------------------------------------------
  // Count step decode
  // ------------------------------------------------------------
  reg up;
  reg dn;
  always @* begin
    up = 1'b0;
    dn = 1'b0;
    case (count_mode_q[3:1])
      3'h0: begin // Up only on A rising
        up = a_rise;
      end
      3'h1: begin // Pulse on A, direction on B
        up = a_rise & ~lvl[1];
        dn = a_rise & lvl[1];
      end
      3'h2: begin // Up on A, down on B
        up = a_rise & ~b_rise;
        dn = b_rise & ~a_rise;
      end
      3'h3: begin // One count per cycle with B low: up on A rising, down on A falling
        up = a_rise & ~lvl[1];
        dn = a_fall & ~lvl[1];
      end
      3'h4: begin // Every edge of A and B
        up = (a_rise & ~lvl[1]) | (a_fall & lvl[1]) | (b_rise & lvl[0]) | (b_fall & ~lvl[0]);
        dn = (a_rise & lvl[1]) | (a_fall & ~lvl[1]) | (b_rise & ~lvl[0]) | (b_fall & lvl[0]);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end
  wire up_mode = (count_mode_q[3:1] == 3'h0);
  wire step_up = counting & ~(ext_used & ext_hold) & up & ~dn;
  wire step_dn = counting & ~(ext_used & ext_hold) & dn & ~up & ~up_mode;
  wire [31:0] acc_inc = acc_q + 32'h00000001;
  wire [31:0] acc_dec = acc_q - 32'h00000001;

  // ------------------------------------------------------------
  // Accumulator, flags, outputs, table index
  // ------------------------------------------------------------
  wire sw_rst = wr_ev & (wa_q == `HSC_CTRL_OFF) & hwdata[`HSC_CTRL_SWRST];
  wire do_rst = sw_rst | (counting & ext_used & ext_rst);
  wire fl_clr = wr_ev & (wa_q == `HSC_STAT_OFF);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 32'h00000000;
      high_preset_hit_flag_q <= 1'b0;
      low_preset_hit_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      unf_flag_q <= 1'b0;
      out_q <= {NOUT{1'b0}};
      tidx_q <= {TAW{1'b0}};
    end else begin
      // Write one to clear; a new event wins
      if (fl_clr) begin
        if (hwdata[`HSC_ST_HIGH]) high_preset_hit_flag_q <= 1'b0;
        if (hwdata[`HSC_ST_LOW]) low_preset_hit_flag_q <= 1'b0;
        if (hwdata[`HSC_ST_OVF]) ovf_flag_q <= 1'b0;
        if (hwdata[`HSC_ST_UNF]) unf_flag_q <= 1'b0;
      end
      if (do_rst) begin // Reset clears count and outputs
        acc_q <= 32'h00000000;
        out_q <= {NOUT{1'b0}};
        tidx_q <= {TAW{1'b0}};
      end else if (step_up) begin
        if ($signed(acc_q) >= $signed(overflow_limit_q)) begin
          ovf_flag_q <= 1'b1;
        end else if (acc_inc == hp) begin
          high_preset_hit_flag_q <= 1'b1;
          out_q <= (out_q & ~output_enable_mask_q) | (hpat & output_enable_mask_q);
          acc_q <= up_mode ? 32'h00000000 : acc_inc;
          if (limit_switch_enable_q & up_mode) begin
            tidx_q <= (tidx_q + 1'b1 >= tcnt_q[TAW-1:0] && !tcnt_q[TAW]) ? {TAW{1'b0}} : tidx_q + 1'b1;
          end
        end else begin
          acc_q <= acc_inc;
        end
      end else if (step_dn) begin // Never in modes 0/1
        if ($signed(acc_q) <= $signed(underflow_limit_q)) begin
          unf_flag_q <= 1'b1;
        end else begin
          acc_q <= acc_dec;
          if (acc_dec == lp) begin
            low_preset_hit_flag_q <= 1'b1;
            out_q <= (out_q & ~output_enable_mask_q) | (lpat & output_enable_mask_q);
            if (limit_switch_enable_q) begin                  // Next pair
              tidx_q <= (tidx_q + 1'b1 >= tcnt_q[TAW-1:0] && !tcnt_q[TAW]) ? {TAW{1'b0}} : tidx_q + 1'b1;
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration register writes
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      limit_switch_enable_q <= 1'b0;
      count_mode_q <= 4'h0;
      counter_instance_select_q <= 3'h0;
      high_preset_q <= 32'h00000000;
      low_preset_q <= 32'h00000000;
      overflow_limit_q <= `HSC_OVF_RST;
      underflow_limit_q <= `HSC_UNF_RST;
      output_enable_mask_q <= {NOUT{1'b0}};
      high_preset_output_pattern_q <= {NOUT{1'b0}};
      low_preset_output_pattern_q <= {NOUT{1'b0}};
      tcnt_q <= {(TAW+1){1'b0}};
    end else if (wr_ev) begin
      case (wa_q)
        `HSC_CTRL_OFF: begin
          run_q <= hwdata[`HSC_CTRL_RUN];
          limit_switch_enable_q <= hwdata[`HSC_CTRL_LSW];
        end
        `HSC_MODE_OFF: begin // Mode low nibble, instance bits 10:8
          count_mode_q <= hwdata[3:0];
          counter_instance_select_q <= hwdata[10:8];
        end
        `HSC_HIGH_OFF: high_preset_q <= hwdata;
        `HSC_LOW_OFF: low_preset_q <= hwdata;
        `HSC_OVF_OFF: overflow_limit_q <= hwdata;
        `HSC_UNF_OFF: underflow_limit_q <= hwdata;
        `HSC_OMASK_OFF: output_enable_mask_q <= hwdata[NOUT-1:0];
        `HSC_HPAT_OFF: high_preset_output_pattern_q <= hwdata[NOUT-1:0];
        `HSC_LPAT_OFF: low_preset_output_pattern_q <= hwdata[NOUT-1:0];
        `HSC_TCNT_OFF: tcnt_q <= (hwdata[8:0] > `HSC_TABLE_MAX) ? `HSC_TABLE_MAX : hwdata[TAW:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Table storage: 16 bytes per entry from table base
  // ------------------------------------------------------------
  // Only the first 64 entries are reachable from the bus; the rest stay zero
  genvar gi;
  generate
    for (gi = 0; gi < TDEPTH; gi = gi + 1) begin : g_tab
      // Table entry write
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tab_high_q[gi] <= 32'h00000000;
          tab_low_q[gi] <= 32'h00000000;
          tab_hpat_q[gi] <= {NOUT{1'b0}};
          tab_lpat_q[gi] <= {NOUT{1'b0}};
        end else if (wr_ev & is_tab(wa_q) & ({26'h0000000, wa_q[9:4]} == gi)) begin
          case (wa_q[3:2])
            2'h0: tab_high_q[gi] <= hwdata;
            2'h1: tab_low_q[gi] <= hwdata;
            2'h2: tab_hpat_q[gi] <= hwdata[NOUT-1:0];
            default: tab_lpat_q[gi] <= hwdata[NOUT-1:0];
          endcase
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read data, registered at the address phase
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      if (is_tab(haddr)) begin
        case (haddr[3:2])
          2'h0: hrdata <= tab_high_q[haddr[9:4]];
          2'h1: hrdata <= tab_low_q[haddr[9:4]];
          2'h2: hrdata <= {{(32-NOUT){1'b0}}, tab_hpat_q[haddr[9:4]]};
          default: hrdata <= {{(32-NOUT){1'b0}}, tab_lpat_q[haddr[9:4]]};
        endcase
      end else begin
        case (haddr)
          `HSC_CTRL_OFF: hrdata <= {30'h00000000, limit_switch_enable_q, run_q};
          `HSC_MODE_OFF: hrdata <= {21'h000000, counter_instance_select_q, 4'h0, count_mode_q};
          `HSC_HIGH_OFF: hrdata <= high_preset_q;
          `HSC_LOW_OFF: hrdata <= low_preset_q;
          `HSC_OVF_OFF: hrdata <= overflow_limit_q;
          `HSC_UNF_OFF: hrdata <= underflow_limit_q;
          `HSC_OMASK_OFF: hrdata <= {{(32-NOUT){1'b0}}, output_enable_mask_q};
          `HSC_HPAT_OFF: hrdata <= {{(32-NOUT){1'b0}}, high_preset_output_pattern_q};
          `HSC_LPAT_OFF: hrdata <= {{(32-NOUT){1'b0}}, low_preset_output_pattern_q};
          `HSC_ACC_OFF: hrdata <= acc_q;
          `HSC_STAT_OFF: hrdata <= {16'h0000, code, 4'h0, unf_flag_q, ovf_flag_q,
                                    low_preset_hit_flag_q, high_preset_hit_flag_q};
          `HSC_TCNT_OFF: hrdata <= {{(31-TAW){1'b0}}, tcnt_q};
          `HSC_TIDX_OFF: hrdata <= {{(32-TAW){1'b0}}, tidx_q};
          default: hrdata <= 32'h00000000; // Unmapped reads zero
        endcase
      end
    end
  end
endmodule

// ==== hsc_chk.sv ====
// Checker for hsc_top: bus answers and output relations.
// Sees only top ports; shadows the mask and the patterns.
`timescale 1ns/1ps
`include "hsc_regs.vh"
module hsc_chk #(
  parameter NOUT = 4
) (
  // Clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Outputs
  input wire [NOUT-1:0] out_q
);
  // ----------------------------------------
  // Shadow of written mask and patterns
  // ----------------------------------------
  wire tk = hsel & hready & htrans[1]; // Transfer taken
  reg w_q; // Write data phase
  reg [11:0] a_q; // Its address
  reg [NOUT-1:0] msk_q; // Mask copy
  reg [NOUT-1:0] pat_q; // All patterns ever written
  // Follow data phases
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 12'h000;
      msk_q <= {NOUT{1'b0}};
      pat_q <= {NOUT{1'b0}};
    end else begin
      w_q <= tk & hwrite;
      a_q <= haddr;
      if (w_q && a_q == `HSC_OMASK_OFF) begin
        msk_q <= hwdata[NOUT-1:0];
      end
      if (w_q && (a_q == `HSC_HPAT_OFF || a_q == `HSC_LPAT_OFF || (a_q[10] && a_q[3]))) begin
        pat_q <= pat_q | hwdata[NOUT-1:0];
      end
    end
  end
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd(a);
    tk && !hwrite && haddr == a;
  endsequence
  sequence s_swrst;
    tk && hwrite && haddr == `HSC_CTRL_OFF ##1 hwdata[`HSC_CTRL_SWRST];
  endsequence
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_hole_zero: assert property (s_rd(12'h100) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_read: assert property (s_rd(`HSC_OMASK_OFF) |=> hrdata[NOUT-1:0] == msk_q)
    else $error("mask read wrong");
  chk_rise_masked: assert property ((out_q & ~$past(out_q) & ~msk_q) == 0)
    else $error("unmasked output rose");
  chk_rise_pattern: assert property ((out_q & ~$past(out_q) & ~pat_q) == 0)
    else $error("output rose outside patterns");
  chk_swrst_clear: assert property (s_swrst |=> out_q == {NOUT{1'b0}})
    else $error("outputs kept over soft reset");
  chk_reset_quiet: assert property ($rose(hresetn) |-> out_q == 0 && hrdata == 0)
    else $error("outputs not quiet after reset");
endmodule
bind hsc_top hsc_chk #(.NOUT(NOUT)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_q(out_q));

// ==== hsc_enc.sv ====
// Pulse source and quadrature encoder on the counter pins.
// Edges are timed freely, unrelated to hclk; pins hold when idle.
`timescale 1ns/1ps
module hsc_enc (
  // Pins
  output wire pin_a,
  output wire pin_b,
  output wire pin_reset,
  output wire pin_hold
);
  localparam int GAP = 437; // Edge spacing, about 9 clocks
  logic [3:0] p = 4'h0; // Hold, reset, B, A
  logic [1:0] gc [4] = '{2'b00, 2'b01, 2'b11, 2'b10}; // Gray steps of B,A
  int ph = 0; // Encoder phase
  assign {pin_hold, pin_reset, pin_b, pin_a} = p;
  // Whole pulses on one line
  task automatic pulse(input int ln, input int n);
    repeat (n) begin
      #GAP p[ln] = 1'b1;
      #GAP p[ln] = 1'b0;
    end
    #GAP;
  endtask
  // Level on one line
  task automatic set(input int ln, input logic v);
    p[ln] = v;
    #GAP;
  endtask
  // Edges forward (A leads) or backward (B leads)
  task automatic quad(input int n);
    repeat (n < 0 ? -n : n) begin
      ph = (ph + (n < 0 ? 3 : 1)) % 4;
      p[1:0] = gc[ph];
      #GAP;
    end
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for hsc_top with a counting model.
// Drives AHB-Lite as sole master; hsc_enc makes the pins.
`timescale 1ns/1ps
`include "hsc_regs.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r; // Last read data
  logic [7:0] lf = 8'h5C; // Random seed
  wire hreadyout, hresp, pin_a, pin_b, pin_reset, pin_hold;
  wire [31:0] hrdata;
  wire [3:0] out_q;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int acc_m, hi_m, lo_m, md_m, ti_m, qph, n1;
  int ovf_m = 32'h7FFFFFFF;
  int unf_m = 32'h80000000;
  int th [2] = '{2, 3}; // Table highs
  logic [3:0] tp [2] = '{4'h1, 4'h4}; // Table patterns
  logic [3:0] msk_m, hp_m, lp_m, out_m, fl_m;
  logic lsw_m = 1'b0;
  int bm [6] = '{10, 1, 3, 7, 9, 0}; // Mode per case
  int bi [6] = '{0, 1, 3, 5, 4, 6}; // Instance per case
  hsc_top #(.NOUT(4), .TDEPTH(255), .TAW(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_a(pin_a),
    .pin_b(pin_b), .pin_reset(pin_reset), .pin_hold(pin_hold), .out_q(out_q));
  hsc_enc enc (.pin_a(pin_a), .pin_b(pin_b), .pin_reset(pin_reset), .pin_hold(pin_hold));
  always #25 hclk = ~hclk;
  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, r);
  endtask
  // Model: one count step
  task automatic step(input int d);
    int n;
    n = acc_m + d;
    if (n > ovf_m) fl_m[2] = 1'b1;
    else if (n < unf_m) fl_m[3] = 1'b1;
    else begin
      acc_m = n;
      if (d > 0 && acc_m == (lsw_m ? th[ti_m] : hi_m)) begin
        fl_m[0] = 1'b1;
        out_m = (out_m & ~msk_m) | ((lsw_m ? tp[ti_m] : hp_m) & msk_m);
        if (md_m < 2) acc_m = 0;
        if (lsw_m && md_m < 2) ti_m = (ti_m + 1) % 2;
      end else if (d < 0 && md_m > 1 && acc_m == lo_m) begin
        fl_m[1] = 1'b1;
        out_m = (out_m & ~msk_m) | (lp_m & msk_m);
      end
    end
  endtask
  task automatic pu(input int ln, input int n, input int d);
    enc.pulse(ln, n);
    repeat (n) step(d);
  endtask
  task automatic qd(input int n, input bit x4);
    int o;
    enc.quad(n);
    repeat (n < 0 ? -n : n) begin
      o = qph;
      qph = (qph + (n < 0 ? 3 : 1)) % 4;
      if (x4 || (n > 0 && qph == 1) || (n < 0 && o == 1)) step(n < 0 ? -1 : 1);
    end
  endtask
  task automatic cfg(input int md, input int ins, input int hi, input int lo);
    wr(`HSC_CTRL_OFF, 32'h0);
    wr(`HSC_MODE_OFF, {21'h0, ins[2:0], 4'h0, md[3:0]});
    wr(`HSC_HIGH_OFF, hi);
    wr(`HSC_LOW_OFF, lo);
    wr(`HSC_OMASK_OFF, {28'h0, msk_m});
    wr(`HSC_HPAT_OFF, {28'h0, hp_m});
    wr(`HSC_LPAT_OFF, {28'h0, lp_m});
    wr(`HSC_STAT_OFF, 32'hF);
    wr(`HSC_CTRL_OFF, {29'h0, 1'b1, lsw_m, 1'b1});
    {md_m, hi_m, lo_m, acc_m, ti_m} = {md, hi, lo, 32'h0, 32'h0};
    {out_m, fl_m} = 8'h00;
  endtask
  task automatic chk(input logic [7:0] code);
    rd("acc", `HSC_ACC_OFF, acc_m);
    rd("status", `HSC_STAT_OFF, {16'h0, code, 4'h0, fl_m});
    cmp("out", {28'h0, out_m}, {28'h0, out_q});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ovf", `HSC_OVF_OFF, 32'h7FFFFFFF);
    rd("unf", `HSC_UNF_OFF, 32'h80000000);
    rd("idle", `HSC_STAT_OFF, 32'h0);
    rd("hole", 12'h100, 32'h0);
    lf = nx(lf);
    {msk_m, hp_m, lp_m} = {lf[3:0] | 4'h1, 4'h1, 4'h2};
    cfg(0, 2, 5, 2);
    pu(0, 7, 1);
    chk(8'h01);
    cfg(2, 3, 3, -1);
    pu(0, 4, 1);
    enc.set(1, 1'b1);
    pu(0, 6, -1);
    enc.set(1, 1'b0);
    chk(8'h01);
    lf = nx(lf);
    n1 = lf[2:0];
    cfg(4, 5, 100, -100);
    pu(0, n1 + 1, 1);
    pu(1, 7 - n1, -1);
    chk(8'h01);
    cfg(6, 1, 4, 2);
    qd(20, 0);
    qd(-8, 0);
    chk(8'h01);
    cfg(8, 0, 6, 5);
    qd(8, 1);
    qd(-4, 1);
    chk(8'h01);
    wr(`HSC_OVF_OFF, 32'h3);
    wr(`HSC_UNF_OFF, 32'hFFFFFFFE);
    {ovf_m, unf_m} = {32'h3, 32'hFFFFFFFE};
    cfg(4, 0, 2, -1);
    pu(0, 5, 1);
    pu(1, 8, -1);
    chk(8'h01);
    cfg(5, 4, 2, -1);
    pu(0, 3, 1);
    enc.set(3, 1'b1);
    enc.pulse(0, 2);
    enc.set(3, 1'b0);
    enc.pulse(2, 1);
    {acc_m, out_m} = 0;
    pu(1, 1, -1);
    chk(8'h01);
    cfg(1, 0, 2, 0);
    pu(0, 3, 1);
    enc.pulse(2, 1);
    {acc_m, out_m} = 0;
    pu(0, 1, 1);
    chk(8'h01);
    cfg(7, 2, 2, -1);
    qd(8, 0);
    enc.set(3, 1'b1);
    enc.quad(4);
    enc.set(3, 1'b0);
    qd(-4, 0);
    chk(8'h01);
    for (int i = 0; i < 6; i++) begin
      cfg(bm[i], bi[i], 100, -100);
      if (i != 4) enc.pulse(0, 2);
      chk(i == 4 ? 8'h01 : 8'h04);
    end
    lsw_m = 1'b1;
    cfg(0, 0, 50, 0);
    chk(8'h04);
    for (int e = 0; e < 2; e++) begin
      wr(`HSC_TABLE_OFF | (e << 4), th[e]);
      wr(`HSC_TABLE_OFF | (e << 4) | 8, {28'h0, tp[e]});
    end
    wr(`HSC_TCNT_OFF, 32'h2);
    cfg(0, 0, 50, 0);
    pu(0, 2, 1);
    rd("index", `HSC_TIDX_OFF, ti_m);
    pu(0, 3, 1);
    chk(8'h01);
    rd("index", `HSC_TIDX_OFF, ti_m);
    close_out();
  end
endmodule
